// File: inc/atd_pkg.sv
// atd_pkg: register offsets, field positions, reset values, timing constants and carrier types
// for the acquisition control block; shared by the top and its two leaf modules.
package atd_pkg;

  // register offsets on the plain host port (word index)
  localparam logic [3:0] ATD_OFS_AD_DATA   = 4'h0;
  localparam logic [3:0] ATD_OFS_STATUS    = 4'h1;
  localparam logic [3:0] ATD_OFS_FIFO      = 4'h2;
  localparam logic [3:0] ATD_OFS_MODE      = 4'h3;
  localparam logic [3:0] ATD_OFS_IRQ_CTRL  = 4'h4;
  localparam logic [3:0] ATD_OFS_IRQ_CLR   = 4'h5;
  localparam logic [3:0] ATD_OFS_DA_MODE   = 4'h6;
  localparam logic [3:0] ATD_OFS_DA1       = 4'h7;
  localparam logic [3:0] ATD_OFS_DA2       = 4'h8;
  localparam logic [3:0] ATD_OFS_SW_TRIG   = 4'hC;

  // mode register fields
  localparam int ATD_MODE_INT_SEL_BIT = 0;
  localparam int ATD_MODE_EXT_SEL_BIT = 1;
  localparam int ATD_MODE_FIFO_EN_BIT = 2;
  localparam int ATD_MODE_DMA_BIT     = 3;
  localparam int ATD_MODE_W           = 4;
  localparam logic [3:0] ATD_MODE_RST = 4'h0;

  // status register fields
  localparam int ATD_ST_BUSY_BIT = 0;
  localparam int ATD_ST_FHS_BIT  = 1;
  localparam int ATD_ST_HALF_BIT = 2;
  localparam int ATD_ST_FULL_BIT = 3;
  localparam int ATD_ST_PEND_BIT = 4;

  // interrupt source select codes
  typedef enum logic [1:0] {
    ATD_IRQ_EXT   = 2'h0,
    ATD_IRQ_EOC   = 2'h1,
    ATD_IRQ_TIMER = 2'h2,
    ATD_IRQ_HALF  = 2'h3
  } atd_irq_src_t;
  localparam int ATD_IRQ_EN_BIT = 2;
  localparam logic [2:0] ATD_IRQ_CTRL_RST = 3'h0;

  // dac update mode: 0 double buffered (reset), 1 transparent
  localparam logic ATD_DA_MODE_RST = 1'b0;
  localparam logic [11:0] ATD_DA_RST = 12'h000;

  // result format
  localparam int ATD_RES_W = 16;
  localparam logic [15:0] ATD_RES_RST = 16'h0000;
  localparam logic [15:0] ATD_MASK_12 = 16'hFFF0;
  localparam int ATD_K_16 = 32767;
  localparam int ATD_K_12 = 32752;

  // fifo geometry
  localparam int ATD_FIFO_DEPTH = 1024;
  localparam int ATD_FIFO_AW    = 10;
  localparam logic [10:0] ATD_FIFO_HALF = 11'h200;

  // conversion timing
  localparam int ATD_CLK_MHZ      = 100;
  localparam int ATD_CONV_MAX_US  = 10;
  localparam int ATD_CONV_CYC     = ATD_CONV_MAX_US * ATD_CLK_MHZ;
  localparam int ATD_CONV_CYC_DEF = ATD_CONV_CYC - 4;

  // converter handshake toward the analog front end
  typedef struct packed {
    logic        start;
    logic [15:0] code;
  } atd_conv_t;

  // host port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } atd_host_req_t;

endpackage

// File: logic/atd_fifo.sv
// atd_fifo: 1k-sample first-in first-out store for conversion results.
// assumes writes and reads are single-cycle pulses on the one clock.
`timescale 1ns/1ps
module atd_fifo (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        clr,
  input  wire logic        push,
  input  wire logic [15:0] push_data,
  input  wire logic        pop,
  output logic [15:0]      pop_data,
  output logic [10:0]      count
);

  logic [15:0]                     mem [atd_pkg::ATD_FIFO_DEPTH];
  logic [atd_pkg::ATD_FIFO_AW-1:0] wptr_q;
  logic [atd_pkg::ATD_FIFO_AW-1:0] rptr_q;
  logic [10:0]                     cnt_q;
  logic                            do_push;
  logic                            do_pop;

  // R18 full drops new
  assign do_push  = push && (cnt_q != 11'(atd_pkg::ATD_FIFO_DEPTH));
  assign do_pop   = pop && (cnt_q != 11'h000);
  assign pop_data = mem[rptr_q];
  assign count    = cnt_q;

  always_ff @(posedge clk) begin
    if (do_push) begin
      mem[wptr_q] <= push_data;
    end
  end

  // R22 oldest first
  always_ff @(posedge clk) begin
    if (!nrst || clr) begin
      wptr_q <= '0;
      rptr_q <= '0;
      cnt_q  <= 11'h000;
    end else begin
      if (do_push) begin
        wptr_q <= wptr_q + 1'b1;
      end
      if (do_pop) begin
        rptr_q <= rptr_q + 1'b1;
      end
      cnt_q <= cnt_q + 11'(do_push) - 11'(do_pop);
    end
  end

endmodule // atd_fifo

// File: logic/atd_dac_ch.sv
// atd_dac_ch: one dac channel, first-stage latch plus output stage.
// assumes the parent decides when the output stage loads.
`timescale 1ns/1ps
module atd_dac_ch (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        wr,
  input  wire logic [11:0] wdata,
  input  wire logic        transparent,
  input  wire logic        update,
  output logic [11:0]      code
);

  logic [11:0] stage_q;
  logic [11:0] out_q;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      stage_q <= atd_pkg::ATD_DA_RST;
    end else if (wr) begin
      stage_q <= wdata;
    end
  end

  // R14 direct load
  // R15 load on update
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_q <= atd_pkg::ATD_DA_RST;
    end else if (transparent && wr) begin
      out_q <= wdata;
    end else if (!transparent && update) begin
      out_q <= wr ? wdata : stage_q;
    end
  end

  assign code = out_q;

endmodule // atd_dac_ch

// File: logic/atd_top.sv
// atd_top: conversion control, result register, sample fifo, interrupt select, dma request, two dacs.
// assumes a synchronous host port (read data one cycle after the read strobe) and an external
// converter that returns conv_done with a code after start; all inputs synchronous to clk.
//
// Contract
// R1: conversion ends within ten microseconds
// R2: busy bit high, register holds newest result
// R3: fifo flag reads one while sample present
// R4: eoc source raises interrupt each conversion
// R5: half-full source raises interrupt at 512
// R6: dma mode: interrupt follows terminal count
// R7: dma request after every conversion
// R8: results are 16-bit two's complement
// R9: 12-bit variant forces low nibble zero
// R10: scale coefficient 32767 or 32752
// R11: software selects one of four sources
// R12: dac code written in one write
// R13: dac takes 12-bit code
// R14: transparent mode updates each channel immediately
// R15: double buffered updates on channel two write
// R16: reset: double buffered, outputs zero
// R17: data register changes only at end
// R18: full fifo discards new results
// R19: trigger source from mode select bits
// R20: software trigger register read starts conversion
// R21: interrupt holds until cleared, unselected ignored; only eoc and half-full latch, ext and timer follow their inputs
// R22: fifo read pops oldest, flags next cycle
`timescale 1ns/1ps
module atd_top #(
  parameter bit RES_12BIT = 1'b0
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [3:0]  addr,
  input  wire logic [15:0] wdata,
  input  wire logic        wr,
  input  wire logic        rd,
  output logic [15:0]      rdata,
  input  wire logic        ext_trig,
  input  wire logic        pacer_tick,
  input  wire logic        ext_irq,
  input  wire logic        timer_irq,
  input  wire logic        dma_ack,
  input  wire logic        dma_tc,
  input  wire logic        conv_done,
  input  wire logic [15:0] conv_code,
  output logic             conv_start,
  output logic             conv_timeout,
  output logic             irq,
  output logic             dma_req,
  output logic [11:0]      da1_code,
  output logic [11:0]      da2_code
);

  typedef enum logic [1:0] {
    ATD_S_IDLE = 2'h0,
    ATD_S_CONV = 2'h1,
    ATD_S_DONE = 2'h2
  } atd_state_t;

  localparam logic [9:0] CONV_LIMIT = 10'(atd_pkg::ATD_CONV_CYC - 1);

  atd_state_t  state_q;
  logic [9:0]  tmr_q;
  logic [15:0] ad_data_q;
  logic        busy_done_q;
  logic [3:0]  mode_q;
  logic [2:0]  irq_ctrl_q;
  logic        da_mode_q;
  logic        ext_q;
  logic        eoc_pend_q;
  logic        half_pend_q;
  logic        half_prev_q;
  logic        irq_q;
  logic        dma_req_q;
  logic        start_q;
  logic        tout_q;
  logic [15:0] rdata_q;
  logic [15:0] fifo_dout;
  logic [10:0] fifo_cnt;
  logic        trig;
  logic        eoc;
  logic        sw_trig;
  logic        fifo_rd;
  logic        half_now;
  logic        fifo_en;
  logic        dma_en;
  logic [15:0] result;
  logic        st_clr;
  logic        da1_wr;
  logic        da2_wr;

  atd_pkg::atd_host_req_t req;
  assign req = '{wr: wr, rd: rd, addr: addr, wdata: wdata};

  assign fifo_en = mode_q[atd_pkg::ATD_MODE_FIFO_EN_BIT];
  assign dma_en  = mode_q[atd_pkg::ATD_MODE_DMA_BIT];
  assign sw_trig = req.rd && (req.addr == atd_pkg::ATD_OFS_SW_TRIG);
  assign fifo_rd = req.rd && (req.addr == atd_pkg::ATD_OFS_FIFO);
  assign st_clr  = req.wr && (req.addr == atd_pkg::ATD_OFS_IRQ_CLR);
  assign da1_wr  = req.wr && (req.addr == atd_pkg::ATD_OFS_DA1);
  assign da2_wr  = req.wr && (req.addr == atd_pkg::ATD_OFS_DA2);

  ////////////////////////////////////////////////////////////////////////////////
  // trigger selection

  // R19 trigger source select
  // R20 read starts conversion
  always_comb begin
    if (mode_q[atd_pkg::ATD_MODE_EXT_SEL_BIT]) begin
      trig = ext_trig && !ext_q;
    end else if (mode_q[atd_pkg::ATD_MODE_INT_SEL_BIT]) begin
      trig = pacer_tick;
    end else begin
      trig = sw_trig;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ext_q <= 1'b0;
    end else begin
      ext_q <= ext_trig;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // conversion sequencer; triggers during a conversion are ignored

  // R8 two's complement passthrough
  // R9 low nibble zeroed
  // R10 code scale preserved
  assign result = RES_12BIT ? (conv_code & atd_pkg::ATD_MASK_12) : conv_code;
  assign eoc    = (state_q == ATD_S_DONE);

  // R1 bounded conversion time
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state_q <= ATD_S_IDLE;
      tmr_q   <= 10'h000;
      start_q <= 1'b0;
      tout_q  <= 1'b0;
    end else begin
      start_q <= 1'b0;
      tout_q  <= 1'b0;
      case (state_q)
        ATD_S_IDLE: begin
          if (trig) begin
            state_q <= ATD_S_CONV;
            tmr_q   <= 10'h000;
            start_q <= 1'b1;
          end
        end
        ATD_S_CONV: begin
          tmr_q <= tmr_q + 10'h001;
          // a silent converter is closed out when tmr_q reaches CONV_LIMIT - 2 so the host never hangs
          if (conv_done || tmr_q == CONV_LIMIT - 10'h002) begin
            state_q <= ATD_S_DONE;
            tout_q  <= !conv_done;
          end
        end
        ATD_S_DONE: state_q <= ATD_S_IDLE;
        default:    state_q <= ATD_S_IDLE;
      endcase
    end
  end

  // R17 update only at end
  // R2 newest result held
  always_ff @(posedge clk) begin
    if (!nrst) begin
      ad_data_q <= atd_pkg::ATD_RES_RST;
    end else if (state_q == ATD_S_CONV && conv_done) begin
      ad_data_q <= result;
    end
  end

  // R2 busy bit high on done
  always_ff @(posedge clk) begin
    if (!nrst) begin
      busy_done_q <= 1'b0;
    end else if (eoc) begin
      busy_done_q <= 1'b1;
    end else if (trig && state_q == ATD_S_IDLE) begin
      busy_done_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // sample fifo

  atd_fifo u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .clr       (!fifo_en),
    .push      (fifo_en && state_q == ATD_S_CONV && conv_done),
    .push_data (result),
    .pop       (fifo_rd && fifo_en),
    .pop_data  (fifo_dout),
    .count     (fifo_cnt)
  );

  assign half_now = fifo_en && (fifo_cnt >= atd_pkg::ATD_FIFO_HALF);

  ////////////////////////////////////////////////////////////////////////////////
  // interrupt sources and dma

  // R21 sticky, set beats clear
  always_ff @(posedge clk) begin
    if (!nrst) begin
      eoc_pend_q  <= 1'b0;
      half_pend_q <= 1'b0;
      half_prev_q <= 1'b0;
    end else begin
      half_prev_q <= half_now;
      eoc_pend_q  <= eoc || (eoc_pend_q && !st_clr);
      // R5 half-full crossing
      half_pend_q <= (half_now && !half_prev_q) || (half_pend_q && !st_clr);
    end
  end

  // R6 dma uses terminal count
  // R11 four source select
  // R4 eoc interrupt
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_q <= 1'b0;
    end else if (dma_en) begin
      irq_q <= dma_tc;
    end else if (!irq_ctrl_q[atd_pkg::ATD_IRQ_EN_BIT]) begin
      irq_q <= 1'b0;
    end else begin
      case (atd_pkg::atd_irq_src_t'(irq_ctrl_q[1:0]))
        atd_pkg::ATD_IRQ_EXT:   irq_q <= ext_irq;
        atd_pkg::ATD_IRQ_EOC:   irq_q <= eoc_pend_q;
        atd_pkg::ATD_IRQ_TIMER: irq_q <= timer_irq;
        atd_pkg::ATD_IRQ_HALF:  irq_q <= half_pend_q;
        default:                irq_q <= 1'b0;
      endcase
    end
  end

  // R7 request per conversion
  always_ff @(posedge clk) begin
    if (!nrst) begin
      dma_req_q <= 1'b0;
    end else if (dma_en && eoc) begin
      dma_req_q <= 1'b1;
    end else if (dma_ack || !dma_en) begin
      dma_req_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge clk) begin
    if (!nrst) begin
      mode_q     <= atd_pkg::ATD_MODE_RST;
      irq_ctrl_q <= atd_pkg::ATD_IRQ_CTRL_RST;
      da_mode_q  <= atd_pkg::ATD_DA_MODE_RST;
    end else if (req.wr) begin
      case (req.addr)
        atd_pkg::ATD_OFS_MODE:     mode_q     <= req.wdata[atd_pkg::ATD_MODE_W-1:0];
        atd_pkg::ATD_OFS_IRQ_CTRL: irq_ctrl_q <= req.wdata[2:0];
        atd_pkg::ATD_OFS_DA_MODE:  da_mode_q  <= req.wdata[0];
        default:                   ;
      endcase
    end
  end

  // R3 flag one when sample present
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdata_q <= 16'h0000;
    end else if (req.rd) begin
      case (req.addr)
        atd_pkg::ATD_OFS_AD_DATA:  rdata_q <= ad_data_q;
        atd_pkg::ATD_OFS_STATUS:   rdata_q <= {11'h000, irq_q, fifo_cnt == 11'(atd_pkg::ATD_FIFO_DEPTH), half_now,
                                               fifo_en && fifo_cnt != 11'h000, busy_done_q};
        atd_pkg::ATD_OFS_FIFO:     rdata_q <= (fifo_en && fifo_cnt != 11'h000) ? fifo_dout : 16'h0000;
        atd_pkg::ATD_OFS_MODE:     rdata_q <= {12'h000, mode_q};
        atd_pkg::ATD_OFS_IRQ_CTRL: rdata_q <= {13'h0000, irq_ctrl_q};
        atd_pkg::ATD_OFS_DA_MODE:  rdata_q <= {15'h0000, da_mode_q};
        default:                   rdata_q <= 16'h0000;
      endcase
    end else begin
      rdata_q <= 16'h0000;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // dac channels

  // R12 single write
  // R13 twelve-bit code
  // R16 reset double buffered zero
  atd_dac_ch u_da1 (
    .clk         (clk),
    .nrst        (nrst),
    .wr          (da1_wr),
    .wdata       (req.wdata[11:0]),
    .transparent (da_mode_q),
    .update      (da2_wr),
    .code        (da1_code)
  );

  atd_dac_ch u_da2 (
    .clk         (clk),
    .nrst        (nrst),
    .wr          (da2_wr),
    .wdata       (req.wdata[11:0]),
    .transparent (da_mode_q),
    .update      (da2_wr),
    .code        (da2_code)
  );

  assign rdata        = rdata_q;
  assign irq          = irq_q;
  assign dma_req      = dma_req_q;
  assign conv_start   = start_q;
  assign conv_timeout = tout_q;

endmodule // atd_top

// File: dv/atd_conv_model.sv
// atd_conv_model: converter and dma controller stand-in for the acquisition block.
// assumes conv_start pulses; lat of zero means the converter never answers.
`timescale 1ns/1ps
module atd_conv_model (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic        conv_start,
  input  wire logic [15:0] code_in,
  input  wire logic [7:0]  lat,
  input  wire logic        dma_req,
  output logic             conv_done,
  output logic [15:0]      conv_code,
  output logic             dma_ack
);
  logic [7:0]  cnt_q;
  logic [15:0] last_q;

  ////////////////////////////////////////
  // code bus shows garbage outside the done pulse so a stale sample is caught
  assign conv_code = conv_done ? last_q : ~last_q;

  always_ff @(posedge clk) begin
    conv_done <= 1'b0;
    if (!nrst) begin
      cnt_q  <= 8'h00;
      last_q <= 16'h0000;
    end else if (conv_start && lat != 8'h00) begin
      cnt_q <= lat;
    end else if (cnt_q != 8'h00) begin
      cnt_q <= cnt_q - 8'h01;
      if (cnt_q == 8'h01) begin
        conv_done <= 1'b1;
        last_q    <= code_in;
      end
    end
  end

  always_ff @(posedge clk) begin
    dma_ack <= nrst && dma_req && !dma_ack;
  end
endmodule // atd_conv_model

// File: dv/atd_top_sva.sv
// atd_top_sva: port-level checks of the acquisition block.
// assumes one clock and synchronous active-low reset.
`timescale 1ns/1ps
module atd_top_sva (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [3:0]  addr,
  input wire logic [15:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] rdata,
  input wire logic        ext_trig,
  input wire logic        pacer_tick,
  input wire logic        dma_ack,
  input wire logic        dma_req,
  input wire logic        conv_done,
  input wire logic        conv_start,
  input wire logic        conv_timeout,
  input wire logic        irq,
  input wire logic [11:0] da1_code,
  input wire logic [11:0] da2_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);

  ////////////////////////////////////////
  a_start_once: assert property (conv_start |=> !conv_start [*3])
    else $error("conversion start repeated");
  a_start_cause: assert property (conv_start |-> $past(rd && addr == 4'hC) || $past(pacer_tick)
    || $past(ext_trig) || $past(ext_trig, 2)) else $error("start without trigger");
  a_conv_bound: assert property (conv_start |-> ##[1:1000] (conv_done || conv_timeout))
    else $error("conversion not closed in time");
  a_no_early_stop: assert property (conv_start |=> !conv_timeout [*8])
    else $error("timeout too early");
  a_dma_drop: assert property (dma_req && dma_ack |=> !dma_req)
    else $error("dma request held after ack");
  a_da1_cause: assert property ($changed(da1_code) |-> $past(wr && (addr == 4'h7 || addr == 4'h8)))
    else $error("dac one moved without write");
  a_da2_cause: assert property ($changed(da2_code) |-> $past(wr && addr == 4'h8))
    else $error("dac two moved without write");
  a_da2_load: assert property (wr && addr == 4'h8 |=> da2_code == $past(wdata[11:0]))
    else $error("dac two code wrong");
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 16'h0000)
    else $error("read data without read");

  c_timeout: cover property (conv_timeout);
  c_dma: cover property (dma_ack);
  c_irq: cover property ($rose(irq));
  c_dac: cover property ($changed(da1_code));
endmodule // atd_top_sva

bind atd_top atd_top_sva i_sva (
  .clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
  .ext_trig(ext_trig), .pacer_tick(pacer_tick), .dma_ack(dma_ack), .dma_req(dma_req),
  .conv_done(conv_done), .conv_start(conv_start), .conv_timeout(conv_timeout), .irq(irq),
  .da1_code(da1_code), .da2_code(da2_code)
);

// File: dv/test_atd_top.sv
// test_atd_top: register-level regression of the acquisition block.
// assumes the converter model answers after lat cycles.
`timescale 1ns/1ps
module test_atd_top;
  logic        clk = 1'b0;
  logic        nrst = 1'b0;
  logic [3:0]  addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic        wr = 1'b0, rd = 1'b0, ext_trig = 1'b0, pacer_tick = 1'b0;
  logic        ext_irq = 1'b0, timer_irq = 1'b0, dma_tc = 1'b0;
  logic        dma_ack, conv_done, conv_start, conv_timeout, irq, dma_req;
  logic [15:0] conv_code, rdata, rdata12, s;
  logic [15:0] code_in = 16'h0000;
  logic [7:0]  lat = 8'h14;
  logic [11:0] da1_code, da2_code;
  logic [15:0] codes [3] = '{16'h7FFF, 16'h0000, 16'h8000};
  int          bad_count = 0, num_checks = 0, dseen = 0, n;

  atd_top i_dut (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
    .rdata(rdata), .ext_trig(ext_trig), .pacer_tick(pacer_tick), .ext_irq(ext_irq),
    .timer_irq(timer_irq), .dma_ack(dma_ack), .dma_tc(dma_tc), .conv_done(conv_done),
    .conv_code(conv_code), .conv_start(conv_start), .conv_timeout(conv_timeout), .irq(irq),
    .dma_req(dma_req), .da1_code(da1_code), .da2_code(da2_code));
  // 12-bit variant runs in lockstep beside the main instance; only its read data is compared
  atd_top #(.RES_12BIT(1'b1)) i_dut12 (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata12), .ext_trig(ext_trig), .pacer_tick(pacer_tick), .ext_irq(ext_irq),
    .timer_irq(timer_irq), .dma_ack(dma_ack), .dma_tc(dma_tc), .conv_done(conv_done),
    .conv_code(conv_code), .conv_start(), .conv_timeout(), .irq(), .dma_req(), .da1_code(),
    .da2_code());
  atd_conv_model i_conv (.clk(clk), .nrst(nrst), .conv_start(conv_start), .code_in(code_in),
    .lat(lat), .dma_req(dma_req), .conv_done(conv_done), .conv_code(conv_code), .dma_ack(dma_ack));

  initial begin
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dma_ack) dseen++;
  end

  ////////////////////////////////////////
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wreg(input logic [3:0] a, input logic [15:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rreg(input logic [3:0] a, output logic [15:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 d = rdata;
  endtask
  task automatic rchk(input logic [3:0] a, input logic [15:0] e);
    logic [15:0] d;
    rreg(a, d);
    chk(d, e);
  endtask
  task automatic dchk(input logic [11:0] e1, input logic [11:0] e2);
    #1;
    chk({4'h0, da1_code}, {4'h0, e1});
    chk({4'h0, da2_code}, {4'h0, e2});
  endtask
  task automatic wait_done();
    logic [15:0] st;
    int k;
    repeat (3) @(posedge clk);
    st = 16'h0000;
    for (k = 0; k < 200 && st[0] !== 1'b1; k++) rreg(4'h1, st);
    if (st[0] !== 1'b1) begin
      bad_count++;
      tally_and_finish();
    end
  endtask
  task automatic conv(input logic [15:0] c);
    code_in = c;
    rreg(4'hC, s);
    wait_done();
  endtask

  ////////////////////////////////////////
  initial begin
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    rchk(4'h6, 16'h0000);
    dchk(12'h000, 12'h000);
    rchk(4'h1, 16'h0000);
    rchk(4'hF, 16'h0000);
    $display("reset test finished");
    foreach (codes[i]) begin
      conv(codes[i]);
      rchk(4'h0, codes[i]);
      chk(rdata12, codes[i] & atd_pkg::ATD_MASK_12);
    end
    code_in = 16'h1234;
    rreg(4'hC, s);
    rchk(4'h0, 16'h8000);
    wait_done();
    rchk(4'h0, 16'h1234);
    $display("software conversion test finished");
    wreg(4'h4, 16'h0005);
    conv(16'h0042);
    chk({15'h0, irq}, 16'h0001);
    repeat (5) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0001);
    wreg(4'h5, 16'h0000);
    repeat (2) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0000);
    wreg(4'h4, 16'h0004);
    timer_irq <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0000);
    @(posedge clk) ext_irq <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0001);
    @(posedge clk) ext_irq <= 1'b0;
    wreg(4'h4, 16'h0006);
    repeat (3) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0001);
    @(posedge clk) timer_irq <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0000);
    $display("interrupt select test finished");
    wreg(4'h4, 16'h0005);
    wreg(4'h3, 16'h0008);
    conv(16'h0777);
    chk(16'(dseen), 16'h0001);
    chk({15'h0, irq}, 16'h0000);
    @(posedge clk) dma_tc <= 1'b1;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0001);
    @(posedge clk) dma_tc <= 1'b0;
    repeat (3) @(posedge clk);
    #1 chk({15'h0, irq}, 16'h0000);
    wreg(4'h4, 16'h0000);
    wreg(4'h5, 16'h0000);
    wreg(4'h3, 16'h0001);
    $display("dma test finished");
    code_in = 16'h0101;
    @(posedge clk) pacer_tick <= 1'b1;
    @(posedge clk) pacer_tick <= 1'b0;
    wait_done();
    rchk(4'h0, 16'h0101);
    wreg(4'h3, 16'h0002);
    code_in = 16'h0202;
    @(posedge clk) ext_trig <= 1'b1;
    wait_done();
    rchk(4'h0, 16'h0202);
    @(posedge clk) ext_trig <= 1'b0;
    $display("trigger source test finished");
    wreg(4'h7, 16'hFABC);
    dchk(12'h000, 12'h000);
    wreg(4'h8, 16'hF123);
    dchk(12'hABC, 12'h123);
    wreg(4'h6, 16'h0001);
    wreg(4'h7, 16'h0456);
    dchk(12'h456, 12'h123);
    wreg(4'h8, 16'h0789);
    dchk(12'h456, 12'h789);
    $display("dac test finished");
    wreg(4'h3, 16'h0004);
    wreg(4'h4, 16'h0007);
    rchk(4'h2, 16'h0000);
    for (int i = 0; i < 1025; i++) begin
      conv(i[15:0]);
      if (i == 510) chk({15'h0, irq}, 16'h0000);
      if (i == 511) chk({15'h0, irq}, 16'h0001);
    end
    rchk(4'h1, 16'h001F);
    for (int i = 0; i < 1024; i++) rchk(4'h2, i[15:0]);
    rchk(4'h1, 16'h0011);
    wreg(4'h4, 16'h0000);
    wreg(4'h3, 16'h0000);
    $display("fifo test finished");
    lat <= 8'h00;
    rreg(4'hC, s);
    for (n = 0; n < 1100 && conv_timeout !== 1'b1; n++) @(posedge clk) #1;
    chk({15'h0, conv_timeout}, 16'h0001);
    rchk(4'h0, 16'h0400);
    $display("timeout test finished");
    tally_and_finish();
  end
endmodule // test_atd_top
